// ==== tb/pcg_pad_model.sv ====
// Pad model for port C: resolves each pin level from device drive, external drive and pull-ups.
// Device drive wins where the bench's switches are also on, as a strong output would.
`default_nettype none

module pcg_pad_model (
	// Clock for the floating-pin pattern
	input wire logic clk,
	// Device side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] weak_pullup_en,
	input wire logic [1:0] nch_pullup_en,
	// Switches and serial bus
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	// Resolved level
	output logic [7:0] level
);
	timeunit 1ns;
	timeprecision 100ps;

	// Undriven, unpulled pins change every cycle so no stale value passes
	logic [7:0] float_q = 8'h5A;

	// Toggle the floating pattern
	always @(posedge clk) begin
		float_q <= ~float_q;
	end

	// Priority: device drive, then external drive, then pull-ups, else floating
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i])
				level[i] = pin_out[i];
			else if (ext_en[i])
				level[i] = ext_val[i];
			else if (weak_pullup_en[i] || (i >= 6 && nch_pullup_en[i - 6]))
				level[i] = 1'b1;
			else
				level[i] = float_q[i];
		end
	end
endmodule // pcg_pad_model

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for port C: APB traffic, random pin setups, change flag, timer pin.
// Assumes the pad model feeds pin_in and a 200 MHz pclk.
`default_nettype none

module tb_top;
	import pcg_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	// Bus and pads
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] pin_in, pin_out, pin_oe_n, weak_pullup_en, ext_val, ext_en, lat, dir;
	logic [1:0] nch_pullup_en;
	// Side inputs and outputs
	logic hibernate, prog_mode, ser_sda_out, ser_sda_oe_n, ser_scl_out, ser_scl_oe_n;
	logic cmp_a_out, ref_a_out, timer0_ext_clock, change_irq;
	logic ser_on, pin7_serial_data, pin6_serial_clock;
	pcg_ctrl_s ctl;
	// Bookkeeping
	int fails, n_tests;
	integer seed = 63;

	pcg_port_c u_pcg_port_c (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.weak_pullup_en(weak_pullup_en), .nch_pullup_en(nch_pullup_en), .hibernate(hibernate),
		.prog_mode(prog_mode), .ser_sda_out(ser_sda_out), .ser_sda_oe_n(ser_sda_oe_n),
		.ser_scl_out(ser_scl_out), .ser_scl_oe_n(ser_scl_oe_n), .pin7_serial_data(pin7_serial_data),
		.pin6_serial_clock(pin6_serial_clock), .cmp_a_out(cmp_a_out), .ref_a_out(ref_a_out),
		.timer0_ext_clock(timer0_ext_clock), .change_irq(change_irq));

	pcg_pad_model u_pcg_pad_model (.clk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.weak_pullup_en(weak_pullup_en), .nch_pullup_en(nch_pullup_en), .ext_val(ext_val),
		.ext_en(ext_en), .level(pin_in));

	// Expected enables: serial engine and analog outputs take over their pins
	function automatic logic [7:0] exp_oe(input logic [7:0] d, input pcg_ctrl_s c, input logic s);
		logic [7:0] r;
		r = d;
		if (c.analog_out_a_enable) r[1:0] = 2'b00;
		if (s) r[7:6] = {ser_sda_oe_n, ser_scl_oe_n};
		return r;
	endfunction

	// Expected drive values, same ownership as above
	function automatic logic [7:0] exp_out(input logic [7:0] l, input pcg_ctrl_s c, input logic s);
		logic [7:0] r;
		r = l;
		if (c.analog_out_a_enable) r[1:0] = {cmp_a_out, ref_a_out};
		if (s) r[7:6] = {ser_sda_out, ser_scl_out};
		return r;
	endfunction

	// Clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait-state count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Verdict
	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		conclude();
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, hibernate, prog_mode} = '0;
		{ser_sda_out, ser_sda_oe_n, ser_scl_out, ser_scl_oe_n, cmp_a_out, ref_a_out} = '0;
		{ext_val, ext_en, fails, n_tests} = '0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Reset state
		apb(1'b0, ADDR_DIRECTION, 32'h0);
		chk(rd, 32'h0000_00FF);
		chk({24'h0, pin_oe_n}, 32'h0000_00FF);
		chk({24'h0, weak_pullup_en}, 32'h0);
		// Latch first, then outputs; pads read back
		lat = 8'($random(seed));
		apb(1'b1, ADDR_PIN_DATA, {24'h0, lat});
		apb(1'b1, ADDR_DIRECTION, 32'h0);
		repeat (3) @(posedge pclk);
		apb(1'b0, ADDR_PIN_DATA, 32'h0);
		chk(rd, {24'h0, lat});
		// Random configurations of latch, direction, modes and alternate sources
		for (int n = 0; n < 40; n++) begin
			lat = 8'($random(seed));
			dir = 8'($random(seed));
			ctl = pcg_ctrl_s'(5'($random(seed)));
			ctl.change_ie = 1'b0;
			if (ctl.analog_out_a_enable) dir[0] = 1'b0;
			{hibernate, prog_mode, ser_sda_out, ser_sda_oe_n} <= 4'($random(seed));
			{ser_scl_out, ser_scl_oe_n, cmp_a_out, ref_a_out} <= 4'($random(seed));
			// Switches on pins 7..6 give the serial copies a known level
			ext_en <= 8'hC0;
			ext_val <= 8'($random(seed));
			apb(1'b1, ADDR_PIN_DATA, {24'h0, lat});
			apb(1'b1, ADDR_CONTROL, {27'h0, ctl});
			apb(1'b1, ADDR_DIRECTION, {24'h0, dir});
			repeat (3) @(posedge pclk);
			ser_on = ctl.serial_en | prog_mode;
			chk(32'(pin_oe_n), 32'(exp_oe(dir, ctl, ser_on)));
			chk(32'(pin_out), 32'(exp_out(lat, ctl, ser_on)));
			chk(32'(weak_pullup_en), 32'((ctl.pullup_disable_n | hibernate) ? 8'h00 : lat & dir & 8'h3F));
			chk(32'(nch_pullup_en), ser_on ? 32'h0 : 32'h3);
			chk(32'(pin7_serial_data), 32'(ser_on ? (ser_sda_oe_n ? ext_val[7] : ser_sda_out) : 1'b1));
			chk(32'(pin6_serial_clock), 32'(ser_on ? (ser_scl_oe_n ? ext_val[6] : ser_scl_out) : 1'b1));
		end
		{hibernate, prog_mode} <= 2'b00;
		// Timer clock pin
		apb(1'b1, ADDR_CONTROL, 32'h0000_0009);
		apb(1'b1, ADDR_DIRECTION, 32'h0000_00FF);
		ext_en <= 8'h08;
		for (int v = 0; v < 2; v++) begin
			ext_val <= {4'h0, v[0], 3'h0};
			repeat (4) @(posedge pclk);
			chk(32'(timer0_ext_clock), 32'(v[0]));
		end
		// Change flag on inputs 7..4
		apb(1'b1, ADDR_CONTROL, 32'h0000_0011);
		ext_en <= 8'hF0;
		ext_val <= 8'($random(seed));
		repeat (2) @(posedge pclk);
		apb(1'b0, ADDR_PIN_DATA, 32'h0);
		apb(1'b1, ADDR_STATUS, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		ext_val[5] <= ~ext_val[5];
		repeat (4) @(posedge pclk);
		chk(32'(change_irq), 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, ADDR_PIN_DATA, 32'h0);
		apb(1'b1, ADDR_STATUS, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		// Output pin 4 is left out of the comparison
		ext_en <= 8'hE0;
		apb(1'b1, ADDR_DIRECTION, 32'h0000_00EF);
		repeat (2) @(posedge pclk);
		apb(1'b0, ADDR_PIN_DATA, 32'h0);
		lat = rd[7:0];
		apb(1'b1, ADDR_STATUS, 32'h1);
		// Flip the driven level of pin 4 against what was just read
		apb(1'b1, ADDR_PIN_DATA, {24'h0, ~lat});
		repeat (4) @(posedge pclk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		// Serial-owned pins 7..6 are left out of the comparison
		{ser_sda_oe_n, ser_scl_oe_n} <= 2'b11;
		apb(1'b1, ADDR_CONTROL, 32'h0000_0015);
		apb(1'b0, ADDR_PIN_DATA, 32'h0);
		apb(1'b1, ADDR_STATUS, 32'h1);
		ext_val[7:6] <= ~ext_val[7:6];
		repeat (4) @(posedge pclk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		// Unmapped address
		apb(1'b0, 12'h100, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		conclude();
	end
endmodule // tb_top

`default_nettype wire

// ==== verilog/pcg_change_det.sv ====
// Mismatch detector for the upper four pins of port C.
// Snapshot comes from the last port read in the top.
`default_nettype none

module pcg_change_det
	import pcg_pkg::*;
(
	// Pin state
	input wire logic [7:4] pin_level,
	input wire logic [7:4] direction,
	input wire logic [7:4] snapshot,
	input wire logic serial_active,
	// Result
	output logic any_mismatch
);

	// Per-pin mismatch, outputs and serial pins take no part
	logic [7:4] mismatch;

	genvar i;
	generate
		for (i = 4; i < 8; i++) begin : g_cmp
			assign mismatch[i] = direction[i] && !(i >= 6 && serial_active)
				&& (pin_level[i] != snapshot[i]);
		end
	endgenerate

	// All mismatches merge into one flag source
	assign any_mismatch = |mismatch;

endmodule : pcg_change_det

`default_nettype wire

// ==== verilog/pcg_pin_mux.sv ====
// Per-pin output, enable and pull-up selection for port C.
// Purely combinational; the top registers everything it produces.
`default_nettype none

module pcg_pin_mux
	import pcg_pkg::*;
(
	// Software state
	input wire logic [7:0] latch,
	input wire logic [7:0] direction,
	input wire pcg_ctrl_s ctrl,
	input wire logic hibernate,
	input wire logic serial_active,
	// Alternate sources
	input wire logic ser_sda_out,
	input wire logic ser_sda_oe_n,
	input wire logic ser_scl_out,
	input wire logic ser_scl_oe_n,
	input wire logic cmp_a_out,
	input wire logic ref_a_out,
	// Result
	output pcg_drive_s drive
);

	// Pull-up allowed at all: enable bit low and not hibernating
	logic pullup_ok;
	// Per-pin results, packed into the carrier once at the end
	logic [7:0] out_v;
	logic [7:0] oe_n_v;
	logic [7:0] weak_v;
	logic [1:0] nch_v;
	assign pullup_ok = !ctrl.pullup_disable_n && !hibernate;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			// Owner of each pin, alternates first
			if (i >= 6) begin : g_serial
				// Serial engine owns the line, direction ignored
				assign out_v[i] = serial_active ? ((i == 7) ? ser_sda_out : ser_scl_out) : latch[i];
				assign oe_n_v[i] = serial_active ? ((i == 7) ? ser_sda_oe_n : ser_scl_oe_n) : direction[i];
				assign weak_v[i] = 1'b0;
				// N-channel pull-up released while the serial bus is in use
				assign nch_v[i - 6] = !serial_active;
			end else if (i <= 1) begin : g_analog
				// Comparator and reference bypass latch and direction
				assign out_v[i] = ctrl.analog_out_a_enable ? ((i == 1) ? cmp_a_out : ref_a_out) : latch[i];
				assign oe_n_v[i] = ctrl.analog_out_a_enable ? 1'b0 : direction[i];
			end else begin : g_plain
				// Plain port: 0 drives the latch, 1 listens
				assign out_v[i] = latch[i];
				assign oe_n_v[i] = direction[i];
			end
			if (i < 6) begin : g_weak
				// Raw direction is used, so analog pin 0 keeps its pull-up unless software clears it
				assign weak_v[i] = latch[i] && direction[i] && pullup_ok;
			end
		end
	endgenerate

	// Carrier order: drive, enable, weak pull-up, N-channel pull-up
	assign drive = {out_v, oe_n_v, weak_v, nch_v};

endmodule : pcg_pin_mux

`default_nettype wire

// ==== verilog/pcg_pkg.sv ====
// Constants, register map and carrier types for the port C pin block.
// Assumes a 200 MHz APB clock and a 12-bit byte address bus.
//
// What this block does
// - Pin 0 input gets pull-up when enabled
// - Pin 0 input without pull-up when disabled
// - Pull-up needs latch 1, input, enable
// - Pin 7 is serial data when serial active
// - Pin 6 is serial clock when serial active
// - N-channel pull-ups off in serial mode
// - Pins 7..4 raise change interrupt when enabled
// - Weak pull-ups only on pins 5..0
// - Pin 3 feeds timer zero external clock
// - Pin 1 carries comparator A output
// - Pin 0 carries reference A output
// - Direction 1 input, 0 drives latch
// - Direction register resets to all ones
// - Direction 7..6 ignored in serial mode
// - Direction 1..0 only gates weak pull-ups in analog mode
// - Inputs 7..4 compared with last read snapshot
// - Weak pull-ups off on outputs, reset, hibernate
// - Analog enable bypasses latch and direction for drive and enable
`default_nettype none

package pcg_pkg;

	// Register indices as printed, byte address is four times the index
	localparam logic [7:0] IDX_PIN_DATA = 8'h07;
	localparam logic [7:0] IDX_DIRECTION = 8'h87;
	localparam logic [7:0] IDX_CONTROL = 8'h10;
	localparam logic [7:0] IDX_STATUS = 8'h11;
	localparam logic [11:0] ADDR_PIN_DATA = {2'h0, IDX_PIN_DATA, 2'h0};
	localparam logic [11:0] ADDR_DIRECTION = {2'h0, IDX_DIRECTION, 2'h0};
	localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

	// Control field positions
	localparam int CTRL_PULLUP_DISABLE_N = 0;
	localparam int CTRL_ANALOG_OUT_A = 1;
	localparam int CTRL_SERIAL_EN = 2;
	localparam int CTRL_TIMER_EXT = 3;
	localparam int CTRL_CHANGE_IE = 4;
	localparam int STAT_CHANGE_FLAG = 0;

	// Reset values
	localparam logic [7:0] DIRECTION_RESET = 8'hFF;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [4:0] CONTROL_RESET = 5'h01;

	// Control register carrier, bit 0 at the bottom
	typedef struct packed {
		logic change_ie;
		logic timer_ext;
		logic serial_en;
		logic analog_out_a_enable;
		logic pullup_disable_n;
	} pcg_ctrl_s;

	// Per-pin drive computed for the next clock
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
		logic [7:0] weak_pullup;
		logic [1:0] nch_pullup;
	} pcg_drive_s;

endpackage : pcg_pkg

`default_nettype wire

// ==== verilog/pcg_port_c.sv ====
// Top of the port C pin block: APB registers, pin drive and change flag.
// Pins arrive synchronous to pclk; external logic resolves pad levels from enables.
`default_nettype none

module pcg_port_c
	import pcg_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pads
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	output logic [7:0] weak_pullup_en,
	output logic [1:0] nch_pullup_en,
	// Device state
	input wire logic hibernate,
	input wire logic prog_mode,
	// Serial engine side
	input wire logic ser_sda_out,
	input wire logic ser_sda_oe_n,
	input wire logic ser_scl_out,
	input wire logic ser_scl_oe_n,
	output logic pin7_serial_data,
	output logic pin6_serial_clock,
	// Analog and timer side
	input wire logic cmp_a_out,
	input wire logic ref_a_out,
	output logic timer0_ext_clock,
	// Change interrupt request
	output logic change_irq
);

	// Software-visible state
	logic [7:0] latch, next_latch; // Output latches
	logic [7:0] direction, next_direction; // 1 = input
	pcg_ctrl_s ctrl, next_ctrl; // Mode bits
	logic change_interrupt_flag, next_change_interrupt_flag; // Sticky change flag
	logic [7:4] snapshot, next_snapshot; // Levels seen at last port read

	// APB answer registers
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// Registered pad and side outputs
	logic [7:0] next_pin_out, next_pin_oe_n, next_weak_pullup_en;
	logic [1:0] next_nch_pullup_en;
	logic next_ser_sda_in, next_ser_scl_in, next_timer_clk, next_change_irq;

	// Decoded bus terms
	logic setup_phase, done, hit;
	logic wr_data, wr_dir, wr_ctrl, wr_stat, rd_data;
	logic serial_active, any_mismatch;
	pcg_drive_s drive;

	// Programming mode takes the same two pins as the serial engine
	assign serial_active = ctrl.serial_en || prog_mode;

	// A transfer completes on the edge where pready is seen high in access
	assign setup_phase = psel && !penable;
	assign done = psel && penable && pready;
	assign hit = (paddr == ADDR_PIN_DATA) || (paddr == ADDR_DIRECTION)
		|| (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS);
	assign wr_data = done && pwrite && (paddr == ADDR_PIN_DATA);
	assign wr_dir = done && pwrite && (paddr == ADDR_DIRECTION);
	assign wr_ctrl = done && pwrite && (paddr == ADDR_CONTROL);
	assign wr_stat = done && pwrite && (paddr == ADDR_STATUS);
	assign rd_data = done && !pwrite && (paddr == ADDR_PIN_DATA);

	// Pin ownership and pull-up selection
	pcg_pin_mux u_mux (
		.latch(latch),
		.direction(direction),
		.ctrl(ctrl),
		.hibernate(hibernate),
		.serial_active(serial_active),
		.ser_sda_out(ser_sda_out),
		.ser_sda_oe_n(ser_sda_oe_n),
		.ser_scl_out(ser_scl_out),
		.ser_scl_oe_n(ser_scl_oe_n),
		.cmp_a_out(cmp_a_out),
		.ref_a_out(ref_a_out),
		.drive(drive)
	);

	// Change comparison on pins 7..4
	pcg_change_det u_chg (
		.pin_level(pin_in[7:4]),
		.direction(direction[7:4]),
		.snapshot(snapshot),
		.serial_active(serial_active),
		.any_mismatch(any_mismatch)
	);

	// Next values of the register file
	always_comb begin
		next_latch = latch;
		next_direction = direction;
		next_ctrl = ctrl;
		next_snapshot = snapshot;
		// Write updates all eight latches, even pins an alternate owns
		if (wr_data) begin
			next_latch = pwdata[7:0];
		end
		if (wr_dir) begin
			next_direction = pwdata[7:0];
		end
		if (wr_ctrl) begin
			next_ctrl = pcg_ctrl_s'(pwdata[4:0]);
		end
		// A port read ends the mismatch by refreshing the snapshot
		if (rd_data) begin
			next_snapshot = prdata[7:4];
		end
		// Set wins over a same-cycle write-one clear
		next_change_interrupt_flag = (change_interrupt_flag && !(wr_stat && pwdata[STAT_CHANGE_FLAG]))
			|| any_mismatch;
	end

	// Register file storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch <= LATCH_RESET;
			direction <= DIRECTION_RESET;
			ctrl <= pcg_ctrl_s'(CONTROL_RESET);
			snapshot <= 4'h0;
			change_interrupt_flag <= 1'b0;
		end else begin
			latch <= next_latch;
			direction <= next_direction;
			ctrl <= next_ctrl;
			snapshot <= next_snapshot;
			change_interrupt_flag <= next_change_interrupt_flag;
		end
	end

	// APB answer: decided in setup, shown in the first access cycle
	always_comb begin
		next_pready = setup_phase;
		next_pslverr = setup_phase && !hit;
		next_prdata = 32'h0;
		if (setup_phase && !pwrite) begin
			case (paddr)
				ADDR_PIN_DATA: next_prdata = {24'h0, pin_in};
				ADDR_DIRECTION: next_prdata = {24'h0, direction};
				ADDR_CONTROL: next_prdata = {27'h0, ctrl};
				ADDR_STATUS: next_prdata = {31'h0, change_interrupt_flag};
				default: next_prdata = 32'h0;
			endcase
		end
	end

	// APB answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Pad and side outputs, one cycle behind the control state
	always_comb begin
		next_pin_out = drive.out;
		next_pin_oe_n = drive.oe_n;
		next_weak_pullup_en = drive.weak_pullup;
		next_nch_pullup_en = drive.nch_pullup;
		// Serial engine hears the pins only while it owns them
		next_ser_sda_in = serial_active ? pin_in[7] : 1'b1;
		next_ser_scl_in = serial_active ? pin_in[6] : 1'b1;
		// Held low when the timer uses its internal clock, avoiding stray counts
		next_timer_clk = ctrl.timer_ext && pin_in[3];
		next_change_irq = change_interrupt_flag && ctrl.change_ie;
	end

	// Output flops; pads start released with pull-ups off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 8'h00;
			pin_oe_n <= 8'hFF;
			weak_pullup_en <= 8'h00;
			nch_pullup_en <= 2'h0;
			pin7_serial_data <= 1'b1;
			pin6_serial_clock <= 1'b1;
			timer0_ext_clock <= 1'b0;
			change_irq <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			weak_pullup_en <= next_weak_pullup_en;
			nch_pullup_en <= next_nch_pullup_en;
			pin7_serial_data <= next_ser_sda_in;
			pin6_serial_clock <= next_ser_scl_in;
			timer0_ext_clock <= next_timer_clk;
			change_irq <= next_change_irq;
		end
	end

	// Pull-up on pin 2 follows latch, direction and enable
	chk_weak_pullup_cause: assert property (@(posedge pclk) disable iff (!presetn)
		##1 weak_pullup_en[2] == $past(latch[2] && direction[2] && !ctrl.pullup_disable_n && !hibernate))
		else $error("weak pull-up on pin 2 wrong");

	// Pins 7 and 6 never carry a weak pull-up
	chk_no_upper_pullup: assert property (@(posedge pclk) disable iff (!presetn)
		weak_pullup_en[7:6] == 2'h0)
		else $error("weak pull-up on pin 7 or 6");

	// Output pin loses its pull-up on the next cycle
	chk_output_no_pullup: assert property (@(posedge pclk) disable iff (!presetn)
		!direction[0] |=> !weak_pullup_en[0])
		else $error("pull-up left on an output pin");

	// Serial mode drops the N-channel pull-ups
	chk_serial_nch_off: assert property (@(posedge pclk) disable iff (!presetn)
		serial_active |=> nch_pullup_en == 2'h0)
		else $error("N-channel pull-up on in serial mode");

	// Serial engine owns pin 7 regardless of direction
	chk_serial_owns_pin: assert property (@(posedge pclk) disable iff (!presetn)
		serial_active |=> pin_oe_n[7] == $past(ser_sda_oe_n) && pin_out[7] == $past(ser_sda_out))
		else $error("pin 7 not under serial engine");

	// Analog enable puts the comparator on pin 1
	chk_analog_owns_pin: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.analog_out_a_enable |=> !pin_oe_n[1] && pin_out[1] == $past(cmp_a_out))
		else $error("pin 1 not driven by comparator");

	// Plain output pin shows the latch
	chk_plain_drive: assert property (@(posedge pclk) disable iff (!presetn)
		!direction[4] |=> !pin_oe_n[4] && pin_out[4] == $past(latch[4]))
		else $error("pin 4 output does not follow latch");

	// A mismatch raises the flag, and the request if enabled
	chk_change_raise: assert property (@(posedge pclk) disable iff (!presetn)
		any_mismatch && ctrl.change_ie |=> change_interrupt_flag ##1 change_irq)
		else $error("change mismatch did not raise request");

	// Timer clock mirrors pin 3 only in external mode
	chk_timer_clock: assert property (@(posedge pclk) disable iff (!presetn)
		##1 timer0_ext_clock == $past(ctrl.timer_ext && pin_in[3]))
		else $error("timer clock input wrong");

	// A completed data write lands in all eight latches
	chk_write_latch: assert property (@(posedge pclk) disable iff (!presetn)
		wr_data |=> latch == $past(pwdata[7:0]))
		else $error("port write did not update latches");

	// Setup is answered in the next cycle, error only for unmapped offsets
	chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready && (pslverr == $past(!hit)))
		else $error("setup not answered in the next cycle");

	// Ready stands one cycle only, so a held access cannot complete twice
	chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held past one cycle");

	// A completed direction write lands in all eight bits
	chk_direction_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_dir |=> direction == $past(pwdata[7:0]))
		else $error("direction write did not land");

	// A port read refreshes the comparison snapshot with the value returned
	chk_snapshot_refresh: assert property (@(posedge pclk) disable iff (!presetn)
		rd_data |=> snapshot == $past(prdata[7:4]))
		else $error("snapshot not refreshed by port read");

	// Upper four pins all outputs can never mismatch
	chk_outputs_no_change: assert property (@(posedge pclk) disable iff (!presetn)
		direction[7:4] == 4'h0 |-> !any_mismatch)
		else $error("output pin took part in change comparison");

	// Write-one clears the flag once the mismatch has ended
	chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr_stat && pwdata[STAT_CHANGE_FLAG] && !any_mismatch |=> !change_interrupt_flag)
		else $error("change flag not cleared");

	// Hibernate removes every weak pull-up on the next cycle
	chk_hibernate_pullup: assert property (@(posedge pclk) disable iff (!presetn)
		hibernate |=> weak_pullup_en == 8'h00)
		else $error("weak pull-up on in hibernate");

	// Analog enable puts the reference on pin 0
	chk_analog_ref_pin: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.analog_out_a_enable |=> !pin_oe_n[0] && pin_out[0] == $past(ref_a_out))
		else $error("pin 0 not driven by reference");

	// Serial engine owns pin 6 regardless of direction
	chk_serial_clock_pin: assert property (@(posedge pclk) disable iff (!presetn)
		serial_active |=> pin_oe_n[6] == $past(ser_scl_oe_n) && pin_out[6] == $past(ser_scl_out))
		else $error("pin 6 not under serial engine");

endmodule : pcg_port_c

`default_nettype wire
